// *** burst_sram_front.sv ***
// Function
// - Inputs captured only on qualified rising edges; output drive and strap on any edge.
// - Unqualified edges sample only output drive (and strap once), advance nothing.
// - Full address incl. burst bits sampled.
// - Lane select gates its byte and parity.
// - Write strobe sampled only on qualified edges.
// - Advance high steps burst counter.
// - Advance low loads a new address.
// - Selected only when first/third low, second high.
// - Qualify high holds state, keeps selection.
// - Read data one qualified clock later.
// - Float on write, first cycle, deselect.
// - Strap picks interleaved or linear order.
`timescale 1ns/1ps
module burst_sram_front
  import sram_front_pkg::*;
(
  input  wire logic   core_clk,          // Clock.
  input  wire logic   resetn,            // Async reset, low.
  input  wire logic   clock_qualify_n,   // Edge qualify, low.
  input  wire upper_t addr_upper,        // Address above burst bits.
  input  wire logic   burst_addr_bit1,   // Burst address bit 1.
  input  wire logic   burst_addr_bit0,   // Burst address bit 0.
  input  wire logic   write_strobe_n,    // Write strobe, low.
  input  wire logic   lane0_write_sel_n, // Lane 0 write select.
  input  wire logic   lane1_write_sel_n, // Lane 1 write select.
  input  wire logic   lane2_write_sel_n, // Lane 2 write select.
  input  wire logic   lane3_write_sel_n, // Lane 3 write select.
  input  wire logic   advance_or_load,   // High steps, low loads.
  input  wire logic   select_first_n,    // Select one, low.
  input  wire logic   select_second,     // Select two, high.
  input  wire logic   select_third_n,    // Select three, low.
  input  wire logic   output_drive_n,    // Output drive, low.
  input  wire logic   burst_order,       // Strap: high interleaved.
  input  wire word_t  data_lanes_in,     // Data pins, input side.
  output word_t       data_lanes_out,    // Data pins, output side.
  output logic        data_oe_n          // Low while driving pins.
);

  access_e    state_r, state_nxt;
  upper_t     upper_r, upper_nxt;
  burst_t     base_r, base_nxt;
  burst_t     cnt_r, cnt_nxt;
  logic       selected, qual, qual_go, rd_start, wr_start;
  addr_t      acc_addr;
  lane_mask_t lane_en;
  logic       wr1_vld_r, wr1_vld_nxt, wr2_vld_r, wr2_vld_nxt;
  addr_t      wr1_addr_r, wr1_addr_nxt, wr2_addr_r, wr2_addr_nxt;
  lane_mask_t wr1_lanes_r, wr1_lanes_nxt, wr2_lanes_r, wr2_lanes_nxt;
  lane_mask_t mem_lane_we;
  word_t      mem_rd_data;
  logic       rd_pend_r, rd_pend_nxt, rd_drv_r, rd_drv_nxt;
  word_t      ent0_r, ent0_nxt, ent1_r, ent1_nxt;
  logic [1:0] vld_r, vld_nxt, drv_r, drv_nxt;
  logic       push, pop, oe_n_nxt;
  logic       interleave_r, interleave_nxt, strap_done_r, strap_done_nxt;

  assign selected = ~select_first_n & select_second & ~select_third_n;
  assign lane_en  = ~{lane3_write_sel_n, lane2_write_sel_n,
                      lane1_write_sel_n, lane0_write_sel_n};
  assign qual     = ~clock_qualify_n;
  // A full read buffer stalls new accesses; in steady use it never fills
  // because every qualified edge also drains the head entry.
  assign qual_go  = qual & ~vld_r[1];

  always_comb begin
    state_nxt = state_r;
    upper_nxt = upper_r;
    base_nxt  = base_r;
    cnt_nxt   = cnt_r;
    if (qual_go) begin
      if (!advance_or_load) begin
        // burst bits load with the upper address.
        upper_nxt = addr_upper;
        base_nxt  = {burst_addr_bit1, burst_addr_bit0};
        cnt_nxt   = CNT_RESET;
        if (!selected) begin
          state_nxt = ST_IDLE;
        end else if (!write_strobe_n) begin
          // strobe seen only on qualified edge.
          state_nxt = ST_WRITE;
        end else begin
          state_nxt = ST_READ;
        end
      end else begin
        cnt_nxt = burst_t'(cnt_r + CNT_STEP);
      end
    end
  end

  assign acc_addr = {upper_nxt, burst_low(base_nxt, cnt_nxt, interleave_r)};
  assign rd_start = qual_go & (state_nxt == ST_READ);
  assign wr_start = qual_go & (state_nxt == ST_WRITE);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= ST_IDLE;
      upper_r <= UPPER_RESET;
      base_r  <= CNT_RESET;
      cnt_r   <= CNT_RESET;
    end else begin
      state_r <= state_nxt;
      upper_r <= upper_nxt;
      base_r  <= base_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  // Write data follows its address by two qualified edges, so a read's
  // output beat never overlaps the data phase of a following write.
  always_comb begin
    wr1_vld_nxt   = wr1_vld_r;
    wr1_addr_nxt  = wr1_addr_r;
    wr1_lanes_nxt = wr1_lanes_r;
    wr2_vld_nxt   = wr2_vld_r;
    wr2_addr_nxt  = wr2_addr_r;
    wr2_lanes_nxt = wr2_lanes_r;
    rd_pend_nxt   = rd_pend_r;
    rd_drv_nxt    = rd_drv_r;
    if (qual_go) begin
      wr1_vld_nxt   = wr_start;
      wr1_addr_nxt  = acc_addr;
      wr1_lanes_nxt = lane_en;
      wr2_vld_nxt   = wr1_vld_r;
      wr2_addr_nxt  = wr1_addr_r;
      wr2_lanes_nxt = wr1_lanes_r;
      rd_pend_nxt   = rd_start;
      // first read after deselect is not driven.
      rd_drv_nxt    = rd_start & (state_r != ST_IDLE);
    end
  end

  // each lane enable gates only its own lane.
  assign mem_lane_we = (qual_go & wr2_vld_r) ? wr2_lanes_r : LANES_NONE;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wr1_vld_r   <= 1'b0;
      wr1_addr_r  <= ADDR_RESET;
      wr1_lanes_r <= LANES_NONE;
      wr2_vld_r   <= 1'b0;
      wr2_addr_r  <= ADDR_RESET;
      wr2_lanes_r <= LANES_NONE;
      rd_pend_r   <= 1'b0;
      rd_drv_r    <= 1'b0;
    end else begin
      wr1_vld_r   <= wr1_vld_nxt;
      wr1_addr_r  <= wr1_addr_nxt;
      wr1_lanes_r <= wr1_lanes_nxt;
      wr2_vld_r   <= wr2_vld_nxt;
      wr2_addr_r  <= wr2_addr_nxt;
      wr2_lanes_r <= wr2_lanes_nxt;
      rd_pend_r   <= rd_pend_nxt;
      rd_drv_r    <= rd_drv_nxt;
    end
  end

  sram_store u_store (
    .clk        (core_clk),
    .rd_en      (rd_start),
    .rd_addr    (acc_addr),
    .rd_data    (mem_rd_data),
    .wr_lane_en (mem_lane_we),
    .wr_addr    (wr2_addr_r),
    .wr_data    (data_lanes_in)
  );

  // read word enters output buffer next qualified edge.
  assign push = qual_go & rd_pend_r;
  assign pop  = qual & vld_r[0];

  // Two-entry shift buffer; the head is always entry 0 so the pins are
  // driven straight from a flop.
  always_comb begin
    ent0_nxt = ent0_r;
    ent1_nxt = ent1_r;
    vld_nxt  = vld_r;
    drv_nxt  = drv_r;
    if (pop) begin
      ent0_nxt = ent1_r;
      vld_nxt  = {1'b0, vld_r[1]};
      drv_nxt  = {1'b0, drv_r[1]};
    end
    if (push) begin
      if (!vld_nxt[0]) begin
        ent0_nxt   = mem_rd_data;
        vld_nxt[0] = 1'b1;
        drv_nxt[0] = rd_drv_r;
      end else begin
        ent1_nxt   = mem_rd_data;
        vld_nxt[1] = 1'b1;
        drv_nxt[1] = rd_drv_r;
      end
    end
    // float on write data, deselect, first beat.
    oe_n_nxt = ~(vld_nxt[0] & drv_nxt[0] & ~output_drive_n & ~wr2_vld_nxt);
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ent0_r    <= WORD_RESET;
      ent1_r    <= WORD_RESET;
      vld_r     <= 2'h0;
      drv_r     <= 2'h0;
      data_oe_n <= 1'b1;
    end else begin
      ent0_r    <= ent0_nxt;
      ent1_r    <= ent1_nxt;
      vld_r     <= vld_nxt;
      drv_r     <= drv_nxt;
      data_oe_n <= oe_n_nxt;
    end
  end

  assign data_lanes_out = ent0_r;

  // strap caught once, first edge after reset.
  always_comb begin
    interleave_nxt = strap_done_r ? interleave_r : burst_order;
    strap_done_nxt = 1'b1;
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      interleave_r <= STRAP_INTERLEAVE;
      strap_done_r <= 1'b0;
    end else begin
      interleave_r <= interleave_nxt;
      strap_done_r <= strap_done_nxt;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  a_hold_on_stall: assert property (
    clock_qualify_n |=> $stable(state_r) && $stable(cnt_r)
                        && $stable(upper_r) && $stable(wr1_vld_r))
    else $error("state moved on an unqualified edge");

  a_keep_selected: assert property (
    (state_r != ST_IDLE) && clock_qualify_n |=> state_r == $past(state_r))
    else $error("qualify high changed the selection");

  a_load_address: assert property (
    qual_go && !advance_or_load |=> upper_r == $past(addr_upper)
      && base_r == {$past(burst_addr_bit1), $past(burst_addr_bit0)}
      && cnt_r == CNT_RESET)
    else $error("load did not capture the address");

  a_advance_step: assert property (
    qual_go && advance_or_load |=> cnt_r == burst_t'($past(cnt_r) + CNT_STEP)
      && base_r == $past(base_r))
    else $error("advance did not step the burst count");

  a_select_decode: assert property (
    qual_go && !advance_or_load |=> (state_r == ST_IDLE)
      == !($past(select_first_n) == 1'b0 && $past(select_second)
           && $past(select_third_n) == 1'b0))
    else $error("chip select decode wrong");

  a_write_lanes: assert property (
    wr_start ##1 (qual_go [*2]) |-> mem_lane_we == $past(lane_en, 2))
    else $error("lane enables do not match sampled selects");

  a_no_desel_write: assert property (
    qual_go && !advance_or_load && !selected |=> !wr1_vld_r
      ##1 (!wr2_vld_r || !$past(qual_go)))
    else $error("deselected edge started a write");

  a_read_latency: assert property (
    rd_start ##1 qual_go |=> vld_r[0] && data_lanes_out == $past(mem_rd_data))
    else $error("read data not in output register one edge later");

  a_float_write: assert property (
    wr2_vld_r |-> data_oe_n)
    else $error("pins driven during write data phase");

  a_float_first: assert property (
    rd_start && state_r == ST_IDLE ##1 qual_go |=> data_oe_n)
    else $error("pins driven on first beat after deselect");

  a_strap_fixed: assert property (
    strap_done_r |=> $stable(interleave_r))
    else $error("burst order changed after capture");

endmodule : burst_sram_front

// *** mem_ctrl_model.sv ***
`timescale 1ns/1ps
module mem_ctrl_model
  import sram_front_pkg::*;
(
  input  wire logic       core_clk, // Clock.
  input  wire logic       resetn,   // Reset, low.
  input  wire logic       qual_n,   // Qualify wanted.
  input  wire logic [1:0] op,       // 0 read, 1 write, 2 step.
  input  wire logic [2:0] sel,      // First_n, second, third_n.
  input  wire addr_t      addr,     // Access address.
  input  wire lane_mask_t lanes,    // Lanes to write.
  input  wire word_t      wdata,    // Word to write.
  output logic            q_n,      // Edge qualify pin.
  output addr_t           a,        // Address pins.
  output logic            we_n,     // Write strobe pin.
  output lane_mask_t      lane_n,   // Lane select pins.
  output logic            adv,      // Advance or load pin.
  output logic [2:0]      csel,     // Select pins.
  output word_t           bus_d     // Data driven to pins.
);
  logic       desel_r;
  logic       ph1_r;
  logic       ph2_r;
  logic [1:0] kind_r;
  logic [1:0] kind;
  word_t      d1_r;
  word_t      d2_r;
  assign adv = (op == 2'h2) && !desel_r;
  assign we_n = (op != 2'h1);
  assign q_n = qual_n;
  assign a = addr;
  assign lane_n = ~lanes;
  assign csel = sel;
  // Outside the data phase the bus drives the inverted word, so it shows no stale word.
  assign bus_d = ph2_r ? d2_r : ~d2_r;
  assign kind = adv ? kind_r : (sel != 3'h2) ? 2'h0 : we_n ? 2'h1 : 2'h2;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      {desel_r, ph1_r, ph2_r, kind_r} <= '0;
      {d1_r, d2_r} <= '0;
    end else if (!qual_n) begin
      desel_r <= (kind == 2'h0);
      kind_r <= kind;
      ph1_r <= (kind == 2'h2);
      ph2_r <= ph1_r;
      d1_r <= wdata;
      d2_r <= d1_r;
    end
  end
endmodule : mem_ctrl_model

// *** sram_front_pkg.sv ***
package sram_front_pkg;

  localparam int ADDR_W    = 18;
  localparam int UPPER_W   = 16;
  localparam int BURST_W   = 2;
  localparam int LANES     = 4;
  localparam int LANE_BITS = 9;
  localparam int DATA_W    = LANES * LANE_BITS;

  typedef logic [ADDR_W-1:0]  addr_t;
  typedef logic [UPPER_W-1:0] upper_t;
  typedef logic [BURST_W-1:0] burst_t;
  typedef logic [DATA_W-1:0]  word_t;
  typedef logic [LANES-1:0]   lane_mask_t;

  // Gray steps along idle, read, write.
  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_READ  = 2'h1,
    ST_WRITE = 2'h3
  } access_e;

  localparam burst_t     CNT_RESET        = 2'h0;
  localparam burst_t     CNT_STEP         = 2'h1;
  localparam logic       STRAP_INTERLEAVE = 1'h1;
  localparam word_t      WORD_RESET       = 36'h0;
  localparam addr_t      ADDR_RESET       = 18'h0;
  localparam upper_t     UPPER_RESET      = 16'h0;
  localparam lane_mask_t LANES_NONE       = 4'h0;

  // Low address bits of a burst beat, interleaved or linear.
  function automatic burst_t burst_low(input burst_t base,
                                       input burst_t cnt,
                                       input logic   interleave);
    burst_low = interleave ? (base ^ cnt) : burst_t'(base + cnt);
  endfunction : burst_low

endpackage : sram_front_pkg

// *** sram_store.sv ***
`timescale 1ns/1ps
module sram_store
  import sram_front_pkg::*;
(
  input  wire logic       clk,        // Core clock.
  input  wire logic       rd_en,      // Read strobe.
  input  wire addr_t      rd_addr,    // Read word address.
  output word_t           rd_data,    // Registered read word.
  input  wire lane_mask_t wr_lane_en, // Per-lane write enable.
  input  wire addr_t      wr_addr,    // Write word address.
  input  wire word_t      wr_data     // Write word.
);

  // Each lane is its own array, so a partial write never touches the
  // neighbouring lanes or their parity bits.
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    logic [LANE_BITS-1:0] mem [0:(1<<ADDR_W)-1];
    logic [LANE_BITS-1:0] rd_lane_r;

    always_ff @(posedge clk) begin
      if (wr_lane_en[g]) begin
        mem[wr_addr] <= wr_data[g*LANE_BITS +: LANE_BITS];
      end
      if (rd_en) begin
        rd_lane_r <= mem[rd_addr];
      end
    end

    assign rd_data[g*LANE_BITS +: LANE_BITS] = rd_lane_r;
  end

endmodule : sram_store

// *** testbench.sv ***
`timescale 1ns/1ps
module testbench;
  import sram_front_pkg::*;
  logic       core_clk = 1'b0;
  logic       resetn = 1'b0;
  logic       qual_n = 1'b0;
  logic       odrv_n = 1'b0;
  logic       order = 1'b1;
  logic [1:0] op = 2'h0;
  logic [2:0] sel = 3'h2;
  addr_t      addr = ADDR_RESET;
  lane_mask_t lanes = 4'hF;
  word_t      wdata = WORD_RESET;
  logic       q_n, we_n, adv, oe_n;
  logic [2:0] csel;
  lane_mask_t lane_n;
  addr_t      a;
  word_t      bus_d, dout, din, mrg;
  int         errors = 0;
  int         total_checks = 0;
  always #10 core_clk = ~core_clk;
  assign din = oe_n ? bus_d : dout;
  mem_ctrl_model ctrl (.core_clk(core_clk), .resetn(resetn), .qual_n(qual_n),
    .op(op), .sel(sel), .addr(addr), .lanes(lanes), .wdata(wdata),
    .q_n(q_n), .a(a), .we_n(we_n), .lane_n(lane_n), .adv(adv),
    .csel(csel), .bus_d(bus_d));
  burst_sram_front dut (.core_clk(core_clk), .resetn(resetn),
    .clock_qualify_n(q_n), .addr_upper(a[17:2]), .burst_addr_bit1(a[1]),
    .burst_addr_bit0(a[0]), .write_strobe_n(we_n),
    .lane0_write_sel_n(lane_n[0]), .lane1_write_sel_n(lane_n[1]),
    .lane2_write_sel_n(lane_n[2]), .lane3_write_sel_n(lane_n[3]),
    .advance_or_load(adv), .select_first_n(csel[2]),
    .select_second(csel[1]), .select_third_n(csel[0]),
    .output_drive_n(odrv_n), .burst_order(order), .data_lanes_in(din),
    .data_lanes_out(dout), .data_oe_n(oe_n));
  function automatic word_t pat(int k);
    pat = word_t'(36'h123456789 * k + 36'h0F0F0F0F1);
  endfunction : pat
  task automatic chk(string what, word_t exp, word_t got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic step(logic [1:0] o, addr_t ad, word_t wd);
    op = o;
    addr = ad;
    wdata = wd;
    @(negedge core_clk);
  endtask : step
  // One read, one filler read, then the word and the drive are judged.
  task automatic rd1(addr_t ad, word_t exp);
    step(2'h0, ad, WORD_RESET);
    step(2'h0, ad, WORD_RESET);
    chk("read word", exp, dout);
    chk("drive", WORD_RESET, word_t'(oe_n));
  endtask : rd1
  task automatic do_reset(logic strap);
    resetn = 1'b0;
    order = strap;
    repeat (8) @(negedge core_clk);
    chk("reset word", WORD_RESET, dout);
    chk("reset float", word_t'(1), word_t'(oe_n));
    resetn = 1'b1;
  endtask : do_reset
  task automatic t_wr_rd();
    step(2'h1, 18'h00010, pat(1));
    step(2'h1, 18'h00020, pat(2));
    step(2'h0, 18'h00030, WORD_RESET);
    rd1(18'h00010, pat(1));
    rd1(18'h00020, pat(2));
    step(2'h0, 18'h00010, WORD_RESET);
    odrv_n = 1'b1;
    step(2'h0, 18'h00010, WORD_RESET);
    odrv_n = 1'b0;
    chk("drive off", word_t'(1), word_t'(oe_n));
  endtask : t_wr_rd
  task automatic t_lanes();
    lanes = 4'h5;
    step(2'h1, 18'h00010, pat(3));
    lanes = 4'hF;
    step(2'h0, 18'h00030, WORD_RESET);
    step(2'h0, 18'h00030, WORD_RESET);
    mrg = (pat(3) & 36'h007FC01FF) | (pat(1) & ~36'h007FC01FF);
    rd1(18'h00010, mrg);
  endtask : t_lanes
  task automatic t_desel();
    logic [2:0] bad [3];
    bad = '{3'h6, 3'h0, 3'h3};
    foreach (bad[i]) begin
      sel = bad[i];
      step(2'h1, 18'h00010, pat(9));
      sel = 3'h2;
      step(2'h0, 18'h00010, WORD_RESET);
      step(2'h0, 18'h00010, WORD_RESET);
      chk("float", word_t'(1), word_t'(oe_n));
      chk("kept", mrg, dout);
      rd1(18'h00010, mrg);
    end
  endtask : t_desel
  task automatic t_qual();
    step(2'h0, 18'h00020, WORD_RESET);
    qual_n = 1'b1;
    repeat (3) step(2'h1, 18'h00020, pat(7));
    chk("stalled", mrg, dout);
    qual_n = 1'b0;
    step(2'h0, 18'h00020, WORD_RESET);
    chk("resumed", pat(2), dout);
    chk("still on", WORD_RESET, word_t'(oe_n));
    rd1(18'h00020, pat(2));
  endtask : t_qual
  task automatic t_burst(logic il);
    addr_t b;
    b = 18'h00101;
    step(2'h1, b, pat(20));
    for (int i = 1; i < 4; i++) step(2'h2, b, pat(20 + i));
    step(2'h0, 18'h00030, WORD_RESET);
    for (int i = 0; i < 4; i++) begin
      b[1:0] = il ? (2'h1 ^ 2'(i)) : 2'(2'h1 + i);
      rd1(b, pat(20 + i));
    end
  endtask : t_burst
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done
  initial begin
    do_reset(1'b1);
    t_wr_rd();
    t_lanes();
    t_desel();
    t_qual();
    t_burst(1'b1);
    do_reset(1'b0);
    t_burst(1'b0);
    test_done();
  end
endmodule : testbench
